// *** src/vconn_fault_supervisor.sv ***
// Purpose: Cable supply switch supervision, discharge, standby, dead battery and fault recovery.
// Assumes: Comparator and detector pins are asynchronous; role, attach and NVM inputs are on clock.
// Notes:   NVM limit, discharge and standby straps are sampled while rst is high; role and dead battery are read live.
`default_nettype none
// How it works
// - As source with discharge enabled, discharge CC for 250 ms after detach.
// - Discharge is off by default; NVM or software write enables it.
// - Current limit is 100 to 600 mA in 50 mA steps, software writable.
// - Power-on or reset reloads the current limit from NVM.
// - Any switch fault sets its flag and raises the alert.
// - Overcurrent sets its flag and alerts at once.
// - Overheat turns switch off until cool, flags, alerts, enters recovery.
// - Input undervoltage turns switch off, updates presence flag, alerts.
// - CC above 6.0 V opens switch until below, flags, alerts.
// - Reverse voltage with switch on opens it, flags, alerts.
// - Standby is off by default and only NVM enables it.
// - Standby at reset or disconnect; powers down; wakes on connection.
// - No standby in sink role with accessory support.
// - Dead battery pull-downs only in sink or dual role.
// - Dead battery sink attach completes, then sink power path enables.
// - Recovery drops source power path and terminations, then unattached source.
// - Recovery on heat, pull-up low, pull-up overvoltage, bus or supply faults.
// - Status bits show fault state or the enable governing its detection.
// - Cable supply only on unwired pin with role, enable, sink, Ra, input ok.
// - Input lockout defaults to 4.65 V; software may select 2.65 V.
module vconn_fault_supervisor
  import vconn_sup_pkg::*;
#(
  parameter int unsigned DISCHARGE_CYCLES = CLK_HZ / 1000 * DISCHARGE_MS,
  parameter int unsigned RECOVERY_CYCLES  = CLK_HZ / 1000 * RECOVERY_MS
) (
  input  wire logic        clock,
  input  wire logic        rst,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // NVM start-up configuration.
  input  wire logic        nvm_discharge_en,
  input  wire logic        nvm_standby_en,
  input  wire logic [3:0]  nvm_ilim,
  input  wire logic [1:0]  nvm_role,
  input  wire logic        nvm_accessory,
  input  wire logic        nvm_dead_battery,
  // Type-C state from the attach logic.
  input  wire logic        partner_attached,
  input  wire logic        acting_source,
  input  wire logic        wired_cc2,
  // Asynchronous comparators and detectors.
  input  wire logic        sw_overcurrent,
  input  wire logic        over_temp,
  input  wire logic        vconn_above_lockout,
  input  wire logic        cc_overvoltage,
  input  wire logic        cc_reverse_voltage,
  input  wire logic        pullup_low,
  input  wire logic        pullup_overvoltage,
  input  wire logic        vbus_in_range,
  input  wire logic        vdd_undervoltage,
  input  wire logic        vdd_overvoltage,
  input  wire logic        connection_seen,
  input  wire logic        ra_on_cc1,
  input  wire logic        ra_on_cc2,
  // Outputs to the analog front end and system.
  output logic             vconn_cc1_on,
  output logic             vconn_cc2_on,
  output logic             discharge_on,
  output logic [3:0]       ilim_code,
  output logic             lockout_low_sel,
  output logic             alert,
  output logic             source_power_path_enable,
  output logic             sink_power_path_enable,
  output logic             terminations_off,
  output logic             standby,
  output logic             dead_battery_term_one,
  output logic             dead_battery_term_two,
  output logic             fault_recovery_state
);

  typedef struct packed {
    state_t             state;
    logic [SYNC_W-1:0]  s1;
    logic [SYNC_W-1:0]  s2;
    logic               present_d;
    logic [4:0]         ctrl;
    logic [3:0]         ilim;
    logic               standby_ok;
    logic [FL_W-1:0]    flags;
    logic [TIMER_W-1:0] rec_cnt;
    logic [TIMER_W-1:0] dis_cnt;
    logic               vc1;
    logic               vc2;
    logic               src_en;
    logic               snk_en;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
  } regs_t;

  regs_t             r;
  regs_t             next_r;
  regs_t             rst_r;
  logic [SYNC_W-1:0] async_in;
  logic              wr_fire;
  logic              rd_fire;
  logic              fault_rec;
  logic              vc_ok;
  logic              attached_now;
  logic              role_not_sink;
  logic              role_not_src;
  logic [FL_W-1:0]   flag_set;
  logic [FL_W-1:0]   flag_clr;
  logic [3:0]        wr_ilim;

  // Comparator pins gathered for the two-stage synchroniser.
  assign async_in = {ra_on_cc2, ra_on_cc1, connection_seen, vdd_overvoltage, vdd_undervoltage,
                     vbus_in_range, pullup_overvoltage, pullup_low, cc_reverse_voltage,
                     cc_overvoltage, vconn_above_lockout, over_temp, sw_overcurrent};

  assign role_not_sink = (nvm_role != ROLE_SINK);
  assign role_not_src  = (nvm_role != ROLE_SOURCE);

  // Reset image: defaults and NVM values are reloaded on every reset.
  // Synchronisers keep sampling through reset, so no false presence change follows its release.
  always_comb begin
    rst_r            = '0;
    rst_r.s1         = async_in;
    rst_r.s2         = r.s1;
    rst_r.present_d  = r.s2[SY_VOK];
    rst_r.ctrl       = CTRL_RST;
    rst_r.ctrl[CT_DISCH] = nvm_discharge_en;
    rst_r.ilim       = (nvm_ilim > ILIM_MAX) ? ILIM_MAX : nvm_ilim;
    rst_r.standby_ok = nvm_standby_en && !(nvm_role == ROLE_SINK && nvm_accessory);
    rst_r.state      = rst_r.standby_ok ? ST_STANDBY : ST_UNATTACHED;
  end

  // Bus handshakes: write needs address and data together, one transfer in flight.
  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !r.bvalid;
  assign rd_fire       = s_axi_arvalid && !r.rvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = !r.rvalid;

  // Next-state logic for the whole block.
  always_comb begin
    next_r    = r;
    flag_clr  = '0;
    wr_ilim   = s_axi_wdata[3:0];
    // Two flip-flop synchroniser on every comparator.
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
    next_r.present_d = r.s2[SY_VOK];

    // Register writes.
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_r.bvalid = 1'b1;
      next_r.bresp  = RESP_OKAY;
      unique case (s_axi_awaddr)
        OFS_CTRL: begin
          if (s_axi_wstrb[0]) begin
            next_r.ctrl = s_axi_wdata[4:0];
          end
        end
        OFS_ILIM: begin
          if (s_axi_wstrb[0]) begin
            next_r.ilim = (wr_ilim > ILIM_MAX) ? ILIM_MAX : wr_ilim;
          end
        end
        OFS_FLAGS: begin
          if (s_axi_wstrb[0]) begin
            flag_clr = s_axi_wdata[FL_W-1:0];
          end
        end
        OFS_STATUS: begin
          next_r.bresp = RESP_OKAY;
        end
        default: begin
          next_r.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Register reads.
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = RESP_OKAY;
      next_r.rdata  = '0;
      unique case (s_axi_araddr)
        OFS_CTRL:   next_r.rdata[4:0] = r.ctrl;
        OFS_ILIM:   next_r.rdata[3:0] = r.ilim;
        OFS_FLAGS:  next_r.rdata[FL_W-1:0] = r.flags;
        OFS_STATUS: begin
          next_r.rdata[0]   = r.s2[SY_VOK];
          next_r.rdata[1]   = !r.s2[SY_PUL];
          next_r.rdata[2]   = r.s2[SY_PUO];
          next_r.rdata[3]   = r.s2[SY_VBS];
          next_r.rdata[4]   = r.ctrl[CT_UV_CHK];
          next_r.rdata[5]   = r.ctrl[CT_OV_CHK];
          next_r.rdata[7:6] = r.state;
          next_r.rdata[8]   = r.vc1;
          next_r.rdata[9]   = r.vc2;
          next_r.rdata[10]  = (r.dis_cnt != '0);
        end
        default: next_r.rresp = RESP_SLVERR;
      endcase
    end

    // Sticky fault flags; a new event wins over a clear in the same cycle.
    flag_set          = '0;
    flag_set[FL_OC]   = r.s2[SY_OCP];
    flag_set[FL_TH]   = r.s2[SY_HOT];
    flag_set[FL_OV]   = r.s2[SY_OVP];
    flag_set[FL_RV]   = r.s2[SY_RVP] && (r.vc1 || r.vc2);
    flag_set[FL_PRES] = r.s2[SY_VOK] ^ r.present_d;
    next_r.flags      = (r.flags & ~flag_clr) | flag_set;

    // Recovery causes; bus and supply checks only count while attached.
    attached_now = (r.state == ST_ATTACHED);
    fault_rec = r.s2[SY_HOT] || r.s2[SY_PUL] || r.s2[SY_PUO] ||
                (attached_now && (!r.s2[SY_VBS] ||
                                  (r.ctrl[CT_UV_CHK] && r.s2[SY_VUV]) ||
                                  (r.ctrl[CT_OV_CHK] && r.s2[SY_VOV])));

    // Discharge timer runs down on its own.
    if (r.dis_cnt != '0) begin
      next_r.dis_cnt = r.dis_cnt - 1'b1;
    end

    // Port state machine.
    unique case (r.state)
      ST_STANDBY: begin
        if (r.s2[SY_CON]) begin
          next_r.state = ST_UNATTACHED;
        end
      end
      ST_UNATTACHED: begin
        if (partner_attached) begin
          next_r.state = ST_ATTACHED;
        end else if (r.standby_ok && !r.s2[SY_CON]) begin
          next_r.state = ST_STANDBY;
        end
      end
      ST_ATTACHED: begin
        if (!partner_attached) begin
          // Standby waits in unattached until the stale connection sample has cleared.
          next_r.state = ST_UNATTACHED;
          if (acting_source && r.ctrl[CT_DISCH]) begin
            next_r.dis_cnt = TIMER_W'(DISCHARGE_CYCLES);
          end
        end
      end
      ST_RECOVERY: begin
        if (r.rec_cnt == '0) begin
          next_r.state = ST_UNATTACHED;
        end else begin
          next_r.rec_cnt = r.rec_cnt - 1'b1;
        end
      end
    endcase

    // Fault entry overrides every other transition; monitors sleep in standby.
    if (fault_rec && r.state != ST_RECOVERY && r.state != ST_STANDBY) begin
      next_r.state   = ST_RECOVERY;
      next_r.rec_cnt = TIMER_W'(RECOVERY_CYCLES - 1);
    end

    // Cable supply switch gating on the unwired pin.
    vc_ok = role_not_sink && r.ctrl[CT_SW_EN] && next_r.state == ST_ATTACHED && acting_source &&
            r.s2[SY_VOK] && !r.s2[SY_HOT] && !r.s2[SY_OVP] && !r.s2[SY_RVP] &&
            next_r.dis_cnt == '0;
    next_r.vc1 = vc_ok && wired_cc2 && r.s2[SY_RA1];
    next_r.vc2 = vc_ok && !wired_cc2 && r.s2[SY_RA2];

    // Power path enables follow the attached state and monitor checks.
    next_r.src_en = next_r.state == ST_ATTACHED && acting_source && role_not_sink && r.s2[SY_VBS] &&
                    !(r.ctrl[CT_UV_CHK] && r.s2[SY_VUV]) &&
                    !(r.ctrl[CT_OV_CHK] && r.s2[SY_VOV]);
    next_r.snk_en = next_r.state == ST_ATTACHED && !acting_source && role_not_src &&
                    r.s2[SY_VBS];
  end

  // Single state register.
  always_ff @(posedge clock) begin
    if (rst) begin
      r <= rst_r;
    end else begin
      r <= next_r;
    end
  end

  // Outputs.
  assign s_axi_bvalid             = r.bvalid;
  assign s_axi_bresp              = r.bresp;
  assign s_axi_rvalid             = r.rvalid;
  assign s_axi_rresp              = r.rresp;
  assign s_axi_rdata              = r.rdata;
  assign vconn_cc1_on             = r.vc1;
  assign vconn_cc2_on             = r.vc2;
  assign discharge_on             = (r.dis_cnt != '0);
  assign ilim_code                = r.ilim;
  assign lockout_low_sel          = r.ctrl[CT_UVLO];
  assign alert                    = |r.flags;
  assign source_power_path_enable = r.src_en;
  assign sink_power_path_enable   = r.snk_en;
  assign fault_recovery_state     = (r.state == ST_RECOVERY);
  assign terminations_off         = (r.state == ST_RECOVERY);
  assign standby                  = (r.state == ST_STANDBY);
  // Dead battery pull-downs outside source role whenever the port is not sourcing or recovering.
  assign dead_battery_term_one    = nvm_dead_battery && role_not_src && !terminations_off &&
                                    !(attached_now && acting_source);
  assign dead_battery_term_two    = dead_battery_term_one;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Checks kept beside the logic they watch.
  a_discharge_len: assert property ($rose(discharge_on) |-> r.dis_cnt == TIMER_W'(DISCHARGE_CYCLES))
    else $error("Discharge did not start with the full period.");
  a_discharge_cause: assert property ($rose(discharge_on) |-> $past(r.ctrl[CT_DISCH]) && $past(acting_source))
    else $error("Discharge started without enable or source role.");
  a_ilim_range: assert property (ilim_code <= ILIM_MAX)
    else $error("Current-limit code out of range.");
  a_ocp_alert: assert property (r.s2[SY_OCP] |=> r.flags[FL_OC] && alert)
    else $error("Overcurrent not flagged on the next cycle.");
  a_hot_recovery: assert property (r.s2[SY_HOT] && attached_now |=> fault_recovery_state && !vconn_cc1_on
                                   && !vconn_cc2_on)
    else $error("Overheat did not open switch and enter recovery.");
  a_ovp_open: assert property (r.s2[SY_OVP] |=> !vconn_cc1_on && !vconn_cc2_on && r.flags[FL_OV])
    else $error("Overvoltage did not open the switch.");
  a_rvp_flag: assert property (r.s2[SY_RVP] && (vconn_cc1_on || vconn_cc2_on) |=> r.flags[FL_RV])
    else $error("Reverse voltage with switch on not flagged.");
  a_recovery_path: assert property ($rose(fault_recovery_state) |-> !source_power_path_enable && terminations_off
                                    ##1 !source_power_path_enable)
    else $error("Source power path active in recovery.");
  a_standby_wake: assert property (standby && r.s2[SY_CON] |=> r.state == ST_UNATTACHED)
    else $error("Standby did not wake on connection.");
  a_vconn_unwired: assert property (vconn_cc1_on |-> !vconn_cc2_on && $past(wired_cc2))
    else $error("Cable supply driven onto the wired pin.");
  a_standby_sleep: assert property (r.state == ST_UNATTACHED && r.standby_ok && !partner_attached
                                    && !r.s2[SY_CON] && !fault_rec |=> standby)
    else $error("Idle port did not return to standby.");
  a_dead_batt_role: assert property ((dead_battery_term_one || dead_battery_term_two)
                                     |-> nvm_role != ROLE_SOURCE && nvm_dead_battery)
    else $error("Dead battery pull-downs presented in source role.");
  a_sink_path: assert property (sink_power_path_enable
                                |-> r.state == ST_ATTACHED && !$past(acting_source))
    else $error("Sink power path enabled outside a sink attachment.");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before acceptance.");

endmodule : vconn_fault_supervisor
`default_nettype wire

// *** src/vconn_sup_pkg.sv ***
// Purpose: Shared constants and types for the cable supply fault supervisor.
// Assumes: 20 MHz system clock, AXI4-Lite register access with 32-bit data.
// Notes:   Timing figures are kept in their own units; cycle counts derive from them.
`default_nettype none
package vconn_sup_pkg;
  // Clock rate and documented times.
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned DISCHARGE_MS = 250;
  localparam int unsigned RECOVERY_MS  = 25;
  localparam int unsigned TIMER_W      = 23;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ILIM   = 8'h04;
  localparam logic [7:0] OFS_FLAGS  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // Control register fields.
  localparam int unsigned CT_DISCH  = 0;
  localparam int unsigned CT_UVLO   = 1;
  localparam int unsigned CT_SW_EN  = 2;
  localparam int unsigned CT_UV_CHK = 3;
  localparam int unsigned CT_OV_CHK = 4;
  localparam logic [4:0]  CTRL_RST  = 5'h04;

  // Current-limit code: limit in mA is ILIM_BASE_MA plus code times ILIM_STEP_MA.
  localparam int unsigned ILIM_BASE_MA = 100;
  localparam int unsigned ILIM_STEP_MA = 50;
  localparam logic [3:0]  ILIM_MAX     = 4'ha;

  // Sticky fault flags.
  localparam int unsigned FL_OC   = 0;
  localparam int unsigned FL_TH   = 1;
  localparam int unsigned FL_OV   = 2;
  localparam int unsigned FL_RV   = 3;
  localparam int unsigned FL_PRES = 4;
  localparam int unsigned FL_W    = 5;

  // Synchronised comparator inputs.
  localparam int unsigned SY_OCP = 0;
  localparam int unsigned SY_HOT = 1;
  localparam int unsigned SY_VOK = 2;
  localparam int unsigned SY_OVP = 3;
  localparam int unsigned SY_RVP = 4;
  localparam int unsigned SY_PUL = 5;
  localparam int unsigned SY_PUO = 6;
  localparam int unsigned SY_VBS = 7;
  localparam int unsigned SY_VUV = 8;
  localparam int unsigned SY_VOV = 9;
  localparam int unsigned SY_CON = 10;
  localparam int unsigned SY_RA1 = 11;
  localparam int unsigned SY_RA2 = 12;
  localparam int unsigned SYNC_W = 13;

  // Configured power role.
  localparam logic [1:0] ROLE_SOURCE = 2'h0;
  localparam logic [1:0] ROLE_SINK   = 2'h1;
  localparam logic [1:0] ROLE_DUAL   = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_STANDBY    = 2'h0,
    ST_UNATTACHED = 2'h1,
    ST_ATTACHED   = 2'h3,
    ST_RECOVERY   = 2'h2
  } state_t;
endpackage : vconn_sup_pkg
`default_nettype wire

// *** tb/cc_partner_model.sv ***
// Purpose: Behavioural port partner or cable seen on the CC lines.
// Assumes: Plug, flip and cable controls come from the bench on the clock.
// Notes:   Attach is reported three clocks after the plug goes in.
`default_nettype none
module cc_partner_model (
  input  wire logic clock,
  input  wire logic plug,
  input  wire logic flip,
  input  wire logic cable_ra,
  output logic      connection_seen,
  output logic      partner_attached,
  output logic      wired_cc2,
  output logic      ra_on_cc1,
  output logic      ra_on_cc2
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] settle;
  // Debounce the plug; pulling it drops the attach at once.
  always_ff @(posedge clock) begin
    if (!plug) begin
      settle <= 2'h0;
    end else if (settle != 2'h3) begin
      settle <= settle + 2'h1;
    end
  end
  // Ra sits only on the pin that the CC wire does not use.
  assign connection_seen  = plug;
  assign partner_attached = plug && settle == 2'h3;
  assign wired_cc2        = flip;
  assign ra_on_cc1        = plug && cable_ra && flip;
  assign ra_on_cc2        = plug && cable_ra && !flip;
endmodule : cc_partner_model
`default_nettype wire

// *** tb/vconn_fault_supervisor_tb.sv ***
// Purpose: Self-checking bench for the cable supply fault supervisor.
// Assumes: Short discharge and recovery counts; partner model on the CC side.
// Notes:   Random current-limit codes and plug orientation from a fixed seed.
`default_nettype none
module vconn_fault_supervisor_tb;
  import vconn_sup_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DC = 20;
  localparam int RC = 8;
  logic        clock = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf, nvm_ilim = 4'h3, ilim_code;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp, nvm_role = ROLE_SOURCE;
  logic        nvm_discharge_en = 0, nvm_standby_en = 0, nvm_accessory = 0, nvm_dead_battery = 0;
  logic        acting_source = 1, plug = 0, flip = 0, cable_ra = 1, sw_overcurrent = 0, over_temp = 0;
  logic        vconn_above_lockout = 1, cc_overvoltage = 0, cc_reverse_voltage = 0, pullup_low = 0;
  logic        pullup_overvoltage = 0, vbus_in_range = 1, vdd_undervoltage = 0, vdd_overvoltage = 0;
  logic        partner_attached, wired_cc2, connection_seen, ra_on_cc1, ra_on_cc2, vconn_cc1_on;
  logic        vconn_cc2_on, discharge_on, lockout_low_sel, alert, source_power_path_enable;
  logic        sink_power_path_enable, terminations_off, standby, dead_battery_term_one;
  logic        dead_battery_term_two, fault_recovery_state, sw_on;
  int          bad_count = 0, tests_run = 0, cycles = 0, seed = 18481, n, m;
  // The switch that should carry the supply is the one on the unwired pin.
  assign sw_on = flip ? vconn_cc1_on : vconn_cc2_on;

  vconn_fault_supervisor #(.DISCHARGE_CYCLES(DC), .RECOVERY_CYCLES(RC)) vconn_fault_supervisor_inst (
    .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .nvm_discharge_en, .nvm_standby_en, .nvm_ilim, .nvm_role, .nvm_accessory, .nvm_dead_battery,
    .partner_attached, .acting_source, .wired_cc2, .sw_overcurrent, .over_temp, .vconn_above_lockout,
    .cc_overvoltage, .cc_reverse_voltage, .pullup_low, .pullup_overvoltage, .vbus_in_range,
    .vdd_undervoltage, .vdd_overvoltage, .connection_seen, .ra_on_cc1, .ra_on_cc2, .vconn_cc1_on,
    .vconn_cc2_on, .discharge_on, .ilim_code, .lockout_low_sel, .alert, .source_power_path_enable,
    .sink_power_path_enable, .terminations_off, .standby, .dead_battery_term_one,
    .dead_battery_term_two, .fault_recovery_state);
  cc_partner_model cc_partner_model_inst (.clock, .plug, .flip, .cable_ra, .connection_seen,
    .partner_attached, .wired_cc2, .ra_on_cc1, .ra_on_cc2);

  // Clock at 20 MHz.
  initial begin
    forever #25 clock = ~clock;
  end

  // Compares a value and counts it; a mismatch is printed at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Expected current-limit code: anything above the top step reads back as the top step.
  function automatic int ilim_expect(input int code);
    return (code > ILIM_MAX) ? ILIM_MAX : code;
  endfunction : ilim_expect

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick

  // One AXI4-Lite write; both channels offered together, held until taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do @(posedge clock); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask : axw

  // One AXI4-Lite read; data and response taken at the rvalid edge.
  task automatic axr(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    rd   = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask : axr

  task automatic reboot();
    rst <= 1'b1;
    tick(16);
    rst <= 1'b0;
    @(posedge clock);
  endtask : reboot

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // Cuts a hang short.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // Main sequence of scenarios.
  initial begin
    flip <= 1'($random(seed));
    reboot();
    axr(OFS_CTRL);
    chk("ctrl", {27'h0, CTRL_RST}, rd);
    chk("ilim", 32'h3, ilim_code);
    chk("standby", 0, standby);
    chk("lockout", 0, lockout_low_sel);
    for (int i = 0; i < 12; i++) begin
      n = (i < 2) ? 10 + 5 * i : $random(seed) & 15;
      m = ilim_expect(n);
      axw(OFS_ILIM, 32'(n));
      axr(OFS_ILIM);
      chk("ilim_rd", m, rd);
      chk("ilim_pin", m, ilim_code);
    end
    axw(8'h20, 32'h1);
    chk("bresp", RESP_SLVERR, resp);
    axr(8'h20);
    chk("rresp", RESP_SLVERR, resp);
    nvm_ilim <= 4'h7;
    reboot();
    chk("ilim_reload", 32'h7, ilim_code);
    axw(OFS_CTRL, 32'h6);
    chk("lockout_low", 1, lockout_low_sel);
    $display("test registers done");
    plug <= 1'b1;
    tick(12);
    axw(OFS_FLAGS, 32'h1f);
    chk("sw_on", 1, sw_on);
    chk("sw_wired", 0, flip ? vconn_cc2_on : vconn_cc1_on);
    for (int f = 0; f < 4; f++) begin
      sw_overcurrent      <= f == 0;
      cc_overvoltage      <= f == 1;
      cc_reverse_voltage  <= f == 2;
      vconn_above_lockout <= f != 3;
      tick(5);
      chk("alert", 1, alert);
      chk("sw_fault", f == 0, sw_on);
      axr(OFS_FLAGS);
      chk("flag", 32'h1 << ((f == 0) ? FL_OC : f + 1), rd);
      {sw_overcurrent, cc_overvoltage, cc_reverse_voltage, vconn_above_lockout} <= 4'h1;
      tick(5);
      axw(OFS_FLAGS, 32'h1f);
      chk("alert_clr", 0, alert);
      chk("sw_back", 1, sw_on);
    end
    $display("test switch faults done");
    axw(OFS_CTRL, 32'h1e);
    axr(OFS_STATUS);
    chk("status", 32'h3b, rd & 32'h3f);
    for (int r = 0; r < 6; r++) begin
      tick(12);
      chk("src_path", 1, source_power_path_enable);
      over_temp          <= r == 0;
      pullup_low         <= r == 1;
      pullup_overvoltage <= r == 2;
      vbus_in_range      <= r != 3;
      vdd_undervoltage   <= r == 4;
      vdd_overvoltage    <= r == 5;
      @(posedge clock);
      {over_temp, pullup_low, pullup_overvoltage, vbus_in_range, vdd_undervoltage, vdd_overvoltage} <= 6'h04;
      m = 0;
      repeat (20) begin
        @(posedge clock);
        m += (fault_recovery_state && terminations_off && !source_power_path_enable && !sw_on);
      end
      chk("recovery", RC, m);
      axr(OFS_FLAGS);
      chk("thermal", (r == 0) << FL_TH, rd & (32'h1 << FL_TH));
      axw(OFS_FLAGS, 32'h1f);
    end
    $display("test recovery done");
    for (int k = 0; k < 3; k++) begin
      axw(OFS_CTRL, (k == 1) ? 32'h4 : 32'h5);
      acting_source <= k != 2;
      plug <= 1'b1;
      tick(12);
      plug <= 1'b0;
      m = 0;
      repeat (40) begin
        @(posedge clock);
        m += discharge_on;
      end
      chk("discharge", (k == 0) ? DC : 0, m);
    end
    $display("test discharge done");
    nvm_standby_en   <= 1'b1;
    nvm_discharge_en <= 1'b1;
    nvm_dead_battery <= 1'b1;
    nvm_role         <= ROLE_SINK;
    reboot();
    chk("standby_rst", 1, standby);
    chk("db_terms", 2'h3, {dead_battery_term_one, dead_battery_term_two});
    axr(OFS_CTRL);
    chk("ctrl_nvm", 32'h5, rd);
    plug <= 1'b1;
    tick(12);
    chk("standby_wake", 0, standby);
    chk("sink_path", 1, sink_power_path_enable);
    plug <= 1'b0;
    tick(12);
    chk("standby_again", 1, standby);
    nvm_accessory <= 1'b1;
    reboot();
    chk("standby_acc", 0, standby);
    nvm_role <= ROLE_SOURCE;
    reboot();
    chk("db_src", 0, {dead_battery_term_one, dead_battery_term_two});
    $display("test standby and dead battery done");
    report_and_stop();
  end
endmodule : vconn_fault_supervisor_tb
`default_nettype wire
